// [common/asi_pkg.sv]
// Purpose: Shared constants, register map and types of the async serial port with IR codec.
// Assumes: Register bus clock and serial reference clock are one 40 MHz clock.
// Notes:   Byte addresses are word aligned; narrower registers sit in the low bits.
package asi_pkg;
   // ----------------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int LP_TICK_HZ = 1_842_000;
   localparam logic [7:0] LP_DIV_RESET = 8'(CLK_HZ / LP_TICK_HZ);
   localparam logic [3:0] LAST_TICK = 4'(16 - 1);
   localparam logic [3:0] SAMPLE_UART = 4'(8 - 1);
   localparam logic [3:0] SAMPLE_IR = 4'(4 - 1);
   localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
   localparam logic [1:0] LP_PULSE_TICKS = 2'h3;
   localparam int DIV_INT_W = 16;
   localparam int DIV_FRAC_W = 6;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;
   // ----------------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_FLAG = 8'h08;
   localparam logic [7:0] ADDR_DIV_INT = 8'h0c;
   localparam logic [7:0] ADDR_DIV_FRAC = 8'h10;
   localparam logic [7:0] ADDR_LINE = 8'h14;
   localparam logic [7:0] ADDR_PORT = 8'h18;
   localparam logic [7:0] ADDR_LEVEL = 8'h1c;
   localparam logic [7:0] ADDR_REQ = 8'h20;
   localparam logic [7:0] ADDR_DMA = 8'h24;
   localparam logic [7:0] ADDR_ID = 8'h28;
   localparam logic [7:0] ADDR_LP_DIV = 8'h2c;
   // Flag register bit positions.
   localparam int FLAG_CTS = 0;
   localparam int FLAG_BUSY = 3;
   localparam int FLAG_RX_EMPTY = 4;
   localparam int FLAG_TX_FULL = 5;
   localparam int FLAG_RX_FULL = 6;
   localparam int FLAG_TX_EMPTY = 7;
   // Reset values.
   localparam logic [6:0] LINE_RESET = 7'h00;
   localparam logic [6:0] PORT_RESET = 7'h18;
   localparam logic [5:0] LEVEL_RESET = 6'h12;
   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] word_length_field;
      logic fifo_on_bit;
      logic two_stop;
      logic even_parity;
      logic parity_on;
      logic send_break;
   } asi_line_s;
   typedef struct packed {
      logic rts_flow;
      logic cts_flow;
      logic rx_on;
      logic tx_on;
      logic ir_lowpower;
      logic ir_on;
      logic port_on_bit;
   } asi_port_s;
   typedef struct packed {
      logic overrun;
      logic line_break;
      logic parity_err;
      logic frame_err;
      logic [7:0] data;
   } asi_rx_entry_s;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} asi_tx_state_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_WAIT} asi_rx_state_e;
endpackage : asi_pkg

// [design/asi_tick_gen.sv]
// Purpose: Fractional divider giving a one-cycle tick every div/2^FRAC clock cycles.
// Assumes: An integer part of zero stops the tick.
// Notes:   The remainder carries over, so the average rate is exact.
`timescale 1ns/1ps
module asi_tick_gen #(
   parameter int W = 22,
   parameter int FRAC = 6
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Divisor and tick
   input wire logic [W-1:0] div,
   output logic tick
);
   localparam logic [W:0] STEP = (W+1)'(1) << FRAC;
   logic [W:0] acc;
   wire logic [W:0] sum = acc + STEP;
   wire logic stopped = (div[W-1:FRAC] == '0);
   wire logic wrap = (sum >= {1'b0, div});

   always_ff @(posedge clock) begin
      if (!resetn || stopped) begin
         acc <= '0;
         tick <= 1'b0;
      end else begin
         acc <= wrap ? sum - {1'b0, div} : sum;
         tick <= wrap;
      end
   end
endmodule : asi_tick_gen

// [design/asi_fifo.sv]
// Purpose: Synchronous FIFO that can shrink to one entry.
// Assumes: Push while full and pop while empty are ignored.
// Notes:   Read data shows the head entry without a pop.
`timescale 1ns/1ps
module asi_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Control
   input wire logic one_deep,
   input wire logic push,
   input wire logic [W-1:0] push_data,
   input wire logic pop,
   // Status and head
   output logic [W-1:0] head,
   output logic [$clog2(DEPTH):0] count,
   output logic full,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   wire logic do_push = push && !full;
   wire logic do_pop = pop && !empty;

   assign full = one_deep ? (count != '0) : (count == (AW+1)'(DEPTH));
   assign empty = (count == '0);
   assign head = mem[rd_ptr];

   always_ff @(posedge clock) begin
      if (do_push) begin
         mem[wr_ptr] <= push_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= wr_ptr + AW'(do_push);
         rd_ptr <= rd_ptr + AW'(do_pop);
         count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule : asi_fifo

// [design/asi_serial_port.sv]
// Purpose: Async serial transceiver with IR pulse codec, FIFOs and a Wishbone slave.
// Assumes: Classic Wishbone, 32-bit data, ack one cycle after the request.
// Notes:   Serial reference clock and bus clock are the same clock here.
//
// What this block does
// - Baud tick comes from a 16-bit integer plus 6-bit fractional divisor.
// - Frames carry 5 to 8 data bits, optional parity, one or two stops.
// - DMA requests, false start rejection, break send and detect, flow control.
// - A read-only identification register tells this port apart.
// - FIFO enable bit switches both FIFOs; off means one entry deep.
// - Transmit FIFO 16 by 8, receive FIFO 16 by 12 with status.
// - Trigger level selectable at 1/8, 1/4, 1/2, 3/4, 7/8 depth.
// - A flag register reports FIFO occupancy for polling.
// - Normal IR sends zero as a 3/16 bit high pulse, one as low.
// - Low-power IR pulse lasts three low-power IR tick periods.
// - Receiver counts ticks on a low idle line; samples at 8th or 4th.
// - Still low at the sample point is a start bit, else false start.
// - Bits sampled every 16 ticks for the word length; parity checked.
// - Stop bit low flags framing error; character and flags go to FIFO.
`timescale 1ns/1ps
module asi_serial_port
   import asi_pkg::*;
#(
   parameter logic [31:0] PORT_ID = 32'h0000_0a51
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial line and flow control
   input wire logic rxd,
   output logic txd,
   input wire logic cts_n,
   output logic rts_n,
   // IR transceiver
   input wire logic ir_rx_in,
   output logic ir_tx_out_n,
   // DMA and level requests
   output logic tx_dma_req,
   output logic rx_dma_req,
   output logic tx_irq_req,
   output logic rx_irq_req
);
   import asi_pkg::*;

   // ----------------------------------------------------------------------
   // Registers and bus decode
   // ----------------------------------------------------------------------
   logic [15:0] div_int;
   logic [5:0] div_frac;
   asi_line_s line_control_reg;
   asi_port_s port_control_reg;
   logic [5:0] fifo_level_select_reg;
   logic [1:0] dma_ctrl;
   logic [7:0] lp_div;
   logic [31:0] next_dat;
   wire logic acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic wr = acc && wb_we_i;
   wire logic rd = acc && !wb_we_i;
   wire logic [7:0] adr = {wb_adr_i[7:2], 2'b00};
   wire logic [31:0] mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire logic [31:0] wd = wb_dat_i & mask;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
      merge = (old & ~m) | nw;
   endfunction : merge

   // Synchronised pins.
   logic rxd_m, rxd_s, ir_m, ir_s, cts_m, cts_s;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         {rxd_m, rxd_s, ir_m, ir_s} <= 4'hc;
         {cts_m, cts_s} <= 2'h3;
      end else begin
         {rxd_m, rxd_s, ir_m, ir_s} <= {rxd, rxd_m, ir_rx_in, ir_m};
         {cts_m, cts_s} <= {cts_n, cts_m};
      end
   end

   // ----------------------------------------------------------------------
   // Ticks and FIFOs
   // ----------------------------------------------------------------------
   logic tick, lp_tick;
   asi_tick_gen #(.W(DIV_INT_W + DIV_FRAC_W), .FRAC(DIV_FRAC_W)) u_baud (
      .clock(clock), .resetn(resetn), .div({div_int, div_frac}), .tick(tick));
   asi_tick_gen #(.W(8), .FRAC(0)) u_lp_tick (
      .clock(clock), .resetn(resetn), .div(lp_div), .tick(lp_tick));

   wire logic fifo_on = line_control_reg.fifo_on_bit;
   logic tx_pop, tx_full, tx_empty, rx_push, rx_full, rx_empty;
   logic [7:0] tx_head;
   logic [CNT_W-1:0] tx_count, rx_count;
   asi_rx_entry_s rx_entry, rx_head;
   wire logic tx_push = wr && adr == ADDR_DATA && wb_sel_i[0];
   wire logic rx_pop = rd && adr == ADDR_DATA;
   asi_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clock(clock), .resetn(resetn), .one_deep(!fifo_on), .push(tx_push), .push_data(wb_dat_i[7:0]),
      .pop(tx_pop), .head(tx_head), .count(tx_count), .full(tx_full), .empty(tx_empty));
   asi_fifo #(.W(12), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clock(clock), .resetn(resetn), .one_deep(!fifo_on), .push(rx_push), .push_data(rx_entry),
      .pop(rx_pop), .head(rx_head), .count(rx_count), .full(rx_full), .empty(rx_empty));

   // Trigger level in entries: code 0..4 gives 1/8, 1/4, 1/2, 3/4, 7/8.
   function automatic logic [CNT_W-1:0] level(input logic [2:0] code);
      case (code)
         3'h0: level = CNT_W'(FIFO_DEPTH / 8);
         3'h1: level = CNT_W'(FIFO_DEPTH / 4);
         3'h2: level = CNT_W'(FIFO_DEPTH / 2);
         3'h3: level = CNT_W'(FIFO_DEPTH * 3 / 4);
         default: level = CNT_W'(FIFO_DEPTH * 7 / 8);
      endcase
   endfunction : level
   wire logic [CNT_W-1:0] tx_level = level(fifo_level_select_reg[2:0]);
   wire logic [CNT_W-1:0] rx_level = level(fifo_level_select_reg[5:3]);
   wire logic next_tx_req = fifo_on ? (tx_count <= tx_level) : tx_empty;
   wire logic next_rx_req = fifo_on ? (rx_count >= rx_level) : !rx_empty;

   // ----------------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------------
   asi_tx_state_e tx_state;
   logic [3:0] tx_cnt;
   logic [2:0] tx_idx;
   logic [7:0] tx_char;
   logic tx_second;
   logic [1:0] lp_cnt;
   wire logic [2:0] last_idx = 3'h4 + {1'b0, line_control_reg.word_length_field};
   wire logic tx_par = line_control_reg.even_parity ? ^tx_char : ~^tx_char;
   wire logic tx_go = port_control_reg.port_on_bit && port_control_reg.tx_on && !tx_empty
      && !(port_control_reg.cts_flow && cts_s);
   wire logic tx_bit_end = tick && tx_cnt == LAST_TICK;
   assign tx_pop = tx_state == TX_IDLE && tx_go;
   wire logic tx_line = tx_state == TX_START ? 1'b0 : tx_state == TX_DATA ? tx_char[tx_idx]
      : tx_state == TX_PARITY ? tx_par : 1'b1;
   wire logic ir_pulse = !tx_line && (port_control_reg.ir_lowpower ? lp_cnt < LP_PULSE_TICKS
      : tx_cnt < IR_PULSE_TICKS);

   always_ff @(posedge clock) begin
      if (!resetn) begin
         tx_state <= TX_IDLE;
         tx_cnt <= '0;
         tx_idx <= '0;
         tx_char <= '0;
         tx_second <= 1'b0;
      end else begin
         if (tick && tx_state != TX_IDLE) begin
            tx_cnt <= tx_cnt + 4'h1;
         end
         case (tx_state)
            TX_IDLE: if (tx_go) begin
               tx_state <= TX_START;
               tx_char <= tx_head & (8'hff >> (2'h3 - line_control_reg.word_length_field));
               tx_cnt <= '0;
               tx_idx <= '0;
               tx_second <= 1'b0;
            end
            TX_START: if (tx_bit_end) begin
               tx_state <= TX_DATA;
            end
            TX_DATA: if (tx_bit_end) begin
               tx_idx <= tx_idx + 3'h1;
               if (tx_idx == last_idx) begin
                  tx_state <= line_control_reg.parity_on ? TX_PARITY : TX_STOP;
               end
            end
            TX_PARITY: if (tx_bit_end) begin
               tx_state <= TX_STOP;
            end
            TX_STOP: if (tx_bit_end) begin
               tx_second <= 1'b1;
               if (!line_control_reg.two_stop || tx_second) begin
                  tx_state <= TX_IDLE;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // Low-power pulse counter restarts at each bit boundary.
   always_ff @(posedge clock) begin
      if (!resetn || tx_bit_end || tx_state == TX_IDLE) begin
         lp_cnt <= '0;
      end else if (lp_tick && lp_cnt != LP_PULSE_TICKS) begin
         lp_cnt <= lp_cnt + 2'h1;
      end
   end

   // ----------------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------------
   asi_rx_state_e rx_state;
   logic [3:0] rx_cnt, ir_hold;
   logic [2:0] rx_idx;
   logic [7:0] rx_char;
   logic rx_perr, rx_all_low, ovr_pend;
   // A zero pulse on the IR input is stretched over one bit time.
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ir_hold <= '0;
      end else if (ir_s) begin
         ir_hold <= LAST_TICK;
      end else if (tick && ir_hold != '0) begin
         ir_hold <= ir_hold - 4'h1;
      end
   end
   wire logic ir_on = port_control_reg.ir_on;
   wire logic rx_line = ir_on ? !(ir_s || ir_hold != '0) : rxd_s;
   wire logic [3:0] samp_pt = ir_on ? SAMPLE_IR : SAMPLE_UART;
   wire logic rx_samp = tick && rx_cnt == LAST_TICK;
   wire logic rx_on = port_control_reg.port_on_bit && port_control_reg.rx_on;
   wire logic stop_done = rx_state == RX_STOP && rx_samp;
   wire logic rx_par_calc = line_control_reg.even_parity ? ^rx_char : ~^rx_char;
   assign rx_push = stop_done && !rx_full;
   assign rx_entry = '{overrun: ovr_pend, line_break: rx_all_low && !rx_line,
      parity_err: rx_perr, frame_err: !rx_line, data: rx_char};

   always_ff @(posedge clock) begin
      if (!resetn) begin
         rx_state <= RX_IDLE;
         rx_cnt <= '0;
         rx_idx <= '0;
         rx_char <= '0;
         rx_perr <= 1'b0;
         rx_all_low <= 1'b0;
      end else begin
         if (tick && rx_state != RX_IDLE) begin
            rx_cnt <= rx_cnt + 4'h1;
         end
         case (rx_state)
            RX_IDLE: if (rx_on && !rx_line) begin
               rx_state <= RX_START;
               rx_cnt <= '0;
               rx_idx <= '0;
               rx_char <= '0;
               rx_perr <= 1'b0;
               rx_all_low <= 1'b1;
            end
            RX_START: if (tick && rx_cnt == samp_pt) begin
               rx_state <= rx_line ? RX_IDLE : RX_DATA;
               rx_cnt <= '0;
            end
            RX_DATA: if (rx_samp) begin
               rx_char[rx_idx] <= rx_line;
               rx_all_low <= rx_all_low && !rx_line;
               rx_idx <= rx_idx + 3'h1;
               if (rx_idx == last_idx) begin
                  rx_state <= line_control_reg.parity_on ? RX_PARITY : RX_STOP;
               end
            end
            RX_PARITY: if (rx_samp) begin
               rx_perr <= rx_line != rx_par_calc;
               rx_all_low <= rx_all_low && !rx_line;
               rx_state <= RX_STOP;
            end
            RX_STOP: if (rx_samp) begin
               rx_state <= rx_line ? RX_IDLE : RX_WAIT;
            end
            RX_WAIT: if (rx_line) begin
               rx_state <= RX_IDLE;
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // An overrun marks the next character that does reach the FIFO.
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ovr_pend <= 1'b0;
      end else if (stop_done) begin
         ovr_pend <= rx_full;
      end
   end

   // ----------------------------------------------------------------------
   // Register access
   // ----------------------------------------------------------------------
   wire logic [7:0] flags = {tx_empty, rx_full, tx_full, rx_empty,
      tx_state != TX_IDLE || !tx_empty, 2'b00, !cts_s};
   always_comb begin
      case (adr)
         ADDR_DATA: next_dat = rx_empty ? '0 : 32'(rx_head);
         ADDR_FLAG: next_dat = 32'(flags);
         ADDR_DIV_INT: next_dat = 32'(div_int);
         ADDR_DIV_FRAC: next_dat = 32'(div_frac);
         ADDR_LINE: next_dat = 32'(line_control_reg);
         ADDR_PORT: next_dat = 32'(port_control_reg);
         ADDR_LEVEL: next_dat = 32'(fifo_level_select_reg);
         ADDR_REQ: next_dat = {30'h0, rx_irq_req, tx_irq_req};
         ADDR_DMA: next_dat = 32'(dma_ctrl);
         ADDR_ID: next_dat = PORT_ID;
         ADDR_LP_DIV: next_dat = 32'(lp_div);
         default: next_dat = '0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         div_int <= '0;
         div_frac <= '0;
         line_control_reg <= LINE_RESET;
         port_control_reg <= PORT_RESET;
         fifo_level_select_reg <= LEVEL_RESET;
         dma_ctrl <= '0;
         lp_div <= LP_DIV_RESET;
      end else if (wr) begin
         case (adr)
            ADDR_DIV_INT: div_int <= 16'(merge(32'(div_int), wd, mask));
            ADDR_DIV_FRAC: div_frac <= 6'(merge(32'(div_frac), wd, mask));
            ADDR_LINE: line_control_reg <= 7'(merge(32'(line_control_reg), wd, mask));
            ADDR_PORT: port_control_reg <= 7'(merge(32'(port_control_reg), wd, mask));
            ADDR_LEVEL: fifo_level_select_reg <= 6'(merge(32'(fifo_level_select_reg), wd, mask));
            ADDR_DMA: dma_ctrl <= 2'(merge(32'(dma_ctrl), wd, mask));
            ADDR_LP_DIV: lp_div <= 8'(merge(32'(lp_div), wd, mask));
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         txd <= 1'b1;
         ir_tx_out_n <= 1'b0;
         rts_n <= 1'b1;
         tx_dma_req <= 1'b0;
         rx_dma_req <= 1'b0;
         tx_irq_req <= 1'b0;
         rx_irq_req <= 1'b0;
      end else begin
         wb_ack_o <= acc;
         wb_dat_o <= rd ? next_dat : '0;
         txd <= !line_control_reg.send_break && (ir_on || tx_line);
         ir_tx_out_n <= ir_on && tx_state != TX_IDLE && ir_pulse;
         rts_n <= port_control_reg.rts_flow && rx_full;
         tx_dma_req <= dma_ctrl[0] && !tx_full;
         rx_dma_req <= dma_ctrl[1] && !rx_empty;
         tx_irq_req <= next_tx_req;
         rx_irq_req <= next_rx_req;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence s_start_check;
      rx_state == RX_START && tick && rx_cnt == samp_pt;
   endsequence
   a_false_start: assert property (s_start_check ##0 rx_line |=> rx_state == RX_IDLE)
      else $error("false start not rejected");
   a_valid_start: assert property (s_start_check ##0 !rx_line |=> rx_state == RX_DATA)
      else $error("valid start not accepted");
   a_start_point: assert property ($rose(rx_state == RX_DATA) |-> $past(rx_cnt) == samp_pt)
      else $error("start bit sampled at wrong tick");
   a_one_deep: assert property (!fifo_on |-> tx_count <= CNT_W'(1) && rx_count <= CNT_W'(1))
      else $error("fifo deeper than one while off");
   a_stop_push: assert property (stop_done && !rx_full |-> rx_push ##1 rx_count == $past(rx_count) + CNT_W'(1)
      || $past(rx_pop))
      else $error("received character not stored");
   a_rx_request: assert property ($rose(rx_irq_req) && $past(fifo_on) |-> $past(rx_count) >= $past(rx_level))
      else $error("receive request below trigger");
   a_baud_spacing: assert property (tick && div_int >= 16'h2 |=> !tick)
      else $error("baud ticks too close");
   a_lp_pulse: assert property (ir_on && port_control_reg.ir_lowpower && ir_tx_out_n
      |-> $past(lp_cnt) < LP_PULSE_TICKS)
      else $error("low-power pulse too long");
   a_flag_empty: assert property (rd && adr == ADDR_FLAG |=> wb_dat_o[FLAG_RX_EMPTY] == $past(rx_empty))
      else $error("flag register wrong");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held for two cycles");
endmodule : asi_serial_port

// [verif/asi_remote_uart.sv]
// Purpose: Remote serial device that drives the receive line of the port.
// Assumes: Bit time is BIT_CLKS clocks and the line idles high.
// Notes:   A short low pulse imitates line noise that must not start a frame.
`timescale 1ns/1ps
module asi_remote_uart #(
   parameter int BIT_CLKS = 32
) (
   // Clock
   input wire logic clock,
   // Serial line
   output logic rxd
);
   initial rxd = 1'b1;
   task automatic send(input logic [7:0] d, input logic stop);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT_CLKS) @(posedge clock);
      end
      rxd <= 1'b1;
   endtask : send
   task automatic glitch(input int n);
      rxd <= 1'b0;
      repeat (n) @(posedge clock);
      rxd <= 1'b1;
   endtask : glitch
endmodule : asi_remote_uart

// [verif/asi_serial_port_tb.sv]
// Purpose: Self-checking bench for the serial port over its register bus.
// Assumes: Divisor 2.0, so one bit lasts 32 clocks.
// Notes:   Wired frames are checked at mid-bit and IR frames at mid-pulse, so small skew never decides a compare.
`timescale 1ns/1ps
module asi_serial_port_tb;
   import asi_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, q;
   logic ack, rxd, txd;
   logic cts_n = 1'b0;
   logic ir_rx = 1'b0;
   logic rts_n, irtx, txdma, rxdma, txirq, rxirq;
   logic [9:0] f;
   int n_errors = 0;
   int checks = 0;
   int cycles = 0;
   always #12.5 clock = ~clock;
   // The identification value is arbitrary.
   asi_serial_port #(.PORT_ID(32'h0000_1234)) i_asi_serial_port (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .ir_rx_in(ir_rx), .ir_tx_out_n(irtx),
      .tx_dma_req(txdma), .rx_dma_req(rxdma), .tx_irq_req(txirq), .rx_irq_req(rxirq));
   asi_remote_uart #(.BIT_CLKS(32)) i_asi_remote_uart (.clock(clock), .rxd(rxd));
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clock); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      bus(1'b0, ADDR_PORT, 0);
      chk(q, 32'h18);
      bus(1'b0, ADDR_LEVEL, 0);
      chk(q, 32'h12);
      bus(1'b0, ADDR_FLAG, 0);
      chk(q & 32'hf9, 32'h91);
      bus(1'b1, ADDR_ID, 32'hffff_ffff);
      bus(1'b0, ADDR_ID, 0);
      chk(q, 32'h0000_1234);
      bus(1'b0, 8'h30, 0);
      chk(q, 32'h0);
      $display("Test registers done");
      bus(1'b1, ADDR_DIV_INT, 32'h2);
      bus(1'b1, ADDR_DIV_FRAC, 32'h0);
      bus(1'b1, ADDR_LINE, 32'h70);
      bus(1'b1, ADDR_PORT, 32'h19);
      bus(1'b1, ADDR_DATA, 32'ha5);
      f = {1'b1, 8'ha5, 1'b0};
      for (int i = 0; i < 400 && txd !== 1'b0; i++) @(posedge clock);
      repeat (16) @(posedge clock);
      for (int i = 0; i < 10; i++) begin
         chk({31'h0, txd}, {31'h0, f[i]});
         repeat (32) @(posedge clock);
      end
      $display("Test transmit done");
      i_asi_remote_uart.send(8'h3c, 1'b1);
      repeat (40) @(posedge clock);
      bus(1'b0, ADDR_DATA, 0);
      chk(q, 32'h03c);
      // A low pulse of four ticks ends before the start sample point.
      i_asi_remote_uart.glitch(8);
      repeat (400) @(posedge clock);
      bus(1'b0, ADDR_FLAG, 0);
      chk({31'h0, q[FLAG_RX_EMPTY]}, 32'h1);
      i_asi_remote_uart.send(8'h5a, 1'b0);
      repeat (40) @(posedge clock);
      bus(1'b0, ADDR_DATA, 0);
      chk(q, 32'h15a);
      $display("Test receive done");
      bus(1'b1, ADDR_DMA, 32'h3);
      bus(1'b0, ADDR_REQ, 0);
      chk(q, 32'h1);
      chk({27'h0, txdma, rxdma, txirq, rxirq, rts_n}, {27'h0, 5'h14});
      $display("Test requests done");
      // Infrared runs last, so no reception follows within the turnaround time.
      bus(1'b1, ADDR_PORT, 32'h1b);
      bus(1'b1, ADDR_DATA, 32'ha5);
      for (int i = 0; i < 400 && irtx !== 1'b1; i++) @(posedge clock);
      for (int i = 0; i < 10; i++) begin
         repeat (3) @(posedge clock);
         chk({30'h0, txd, irtx}, {30'h0, 1'b1, ~f[i]});
         repeat (29) @(posedge clock);
      end
      $display("Test infrared done");
      end_sim();
   end
endmodule : asi_serial_port_tb
